// ==== shared/cpu_exec_pkg.sv ====
// Purpose: shared constants and types of the bit-op / load-store executor
// Assumes: one clock, synchronous active-high reset, APB register access
// Notes:   status_register bits are C0 Z1 N2 V3 S4 H5 T6 I7
// Overview of operation
// - rotate right through carry, flags Z C N V
// - arithmetic shift right keeps bit 7, flags ZCNV
// - nibble swap, flags untouched, one cycle
// - selected source bit copied into transfer flag
// - transfer flag written into selected destination bit
// - flag set forces operand-chosen status bit high
// - flag clear forces operand-chosen status bit low
// - overflow flag set or cleared alone
// - post-increment load: read then pointer plus one
// - pre-decrement load: pointer minus one then read
// - displacement load via upper pointers, pointer kept
// - direct load from constant address, two cycles
// - post-increment store: write then pointer plus one
// - pre-decrement store: pointer minus one then write
package cpu_exec_pkg;
	// apb byte offsets
	localparam logic [7:0] ADDR_CMD      = 8'h00;
	localparam logic [7:0] ADDR_OPERAND  = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam int         REGWIN_BIT    = 7;
	// command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_RD_LSB  = 8;
	localparam int CMD_RR_LSB  = 16;
	localparam int CMD_BIT_LSB = 24;
	localparam int CMD_PTR_LSB = 28;
	// status word fields
	localparam int STATUS_BUSY_BIT = 8;
	localparam int STATUS_ERR_BIT  = 9;
	// reset values
	localparam logic [31:0] CMD_RESET     = 32'h0000_0000;
	localparam logic [15:0] OPERAND_RESET = 16'h0000;
	localparam logic [7:0]  STATUS_REGISTER_RESET    = 8'h00;
	localparam logic [7:0]  REG_RESET     = 8'h00;
	// status register bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	// pointer select and pair index of the lowest pointer
	localparam logic [1:0] PTR_X    = 2'h0;
	localparam logic [1:0] PTR_NONE = 2'h3;
	localparam logic [3:0] PTR_PAIR_BASE = 4'hd;
	typedef enum logic [4:0] {
		OP_NOP                  = 5'h00,
		OP_ROTATE_RIGHT_CARRY   = 5'h01,
		OP_ARITH_SHIFT_RIGHT    = 5'h02,
		OP_NIBBLE_SWAP          = 5'h03,
		OP_FLAG_SET_GENERIC     = 5'h04,
		OP_FLAG_CLEAR_GENERIC   = 5'h05,
		OP_BIT_TO_TRANSFER_FLAG = 5'h06,
		OP_TRANSFER_FLAG_TO_BIT = 5'h07,
		OP_REGISTER_MOVE        = 5'h08,
		OP_REGISTER_PAIR_COPY   = 5'h09,
		OP_IMMEDIATE_LOAD       = 5'h0a,
		OP_INDIRECT_LOAD        = 5'h0b,
		OP_LOAD_POST_INC        = 5'h0c,
		OP_LOAD_PRE_DEC         = 5'h0d,
		OP_DISPLACEMENT_LOAD    = 5'h0e,
		OP_DIRECT_LOAD          = 5'h0f,
		OP_INDIRECT_STORE       = 5'h10,
		OP_STORE_POST_INC       = 5'h11,
		OP_STORE_PRE_DEC        = 5'h12
	} op_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_EXEC = 3'b010,
		S_MEM  = 3'b100
	} exec_state_t;
endpackage

// ==== design/work_regs.sv ====
// Purpose: 32 x 8 working register file
// Assumes: word and byte writes never target the same byte in one cycle
// Notes:   all reads are combinational
`timescale 1ns/10ps
`default_nettype none
module work_regs (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [4:0]  a_addr,
	input  wire logic [4:0]  b_addr,
	input  wire logic [4:0]  c_addr,
	input  wire logic [3:0]  p_pair,
	input  wire logic [3:0]  q_pair,
	input  wire logic        byte_we,
	input  wire logic [4:0]  byte_addr,
	input  wire logic [7:0]  byte_data,
	input  wire logic        word_we,
	input  wire logic [3:0]  word_pair,
	input  wire logic [15:0] word_data,
	output wire logic [7:0]  a_data,
	output wire logic [7:0]  b_data,
	output wire logic [7:0]  c_data,
	output wire logic [15:0] p_data,
	output wire logic [15:0] q_data
);
	logic [7:0] regs [0:31];

	// read ports; a pair is low byte at even index
	assign a_data = regs[a_addr];
	assign b_data = regs[b_addr];
	assign c_data = regs[c_addr];
	assign p_data = {regs[{p_pair, 1'b1}], regs[{p_pair, 1'b0}]};
	assign q_data = {regs[{q_pair, 1'b1}], regs[{q_pair, 1'b0}]};

	// byte write placed last so it wins on a clash
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			for (int i = 0; i < 32; i++)
				regs[i] <= cpu_exec_pkg::REG_RESET;
		end
		else
		begin
			if (word_we)
			begin
				regs[{word_pair, 1'b0}] <= word_data[7:0];
				regs[{word_pair, 1'b1}] <= word_data[15:8];
			end
			if (byte_we)
				regs[byte_addr] <= byte_data;
		end
	end
endmodule
`default_nettype wire

// ==== design/exec_alu.sv ====
// Purpose: single-cycle result and flag logic
// Assumes: op is decoded by the caller; memory ops yield no result
// Notes:   only the four shift flags move on shifts; S is left alone
`timescale 1ns/10ps
`default_nettype none
module exec_alu (
	input  wire logic [4:0] op,
	input  wire logic [7:0] rd_val,
	input  wire logic [7:0] rr_val,
	input  wire logic [2:0] bit_sel,
	input  wire logic [7:0] imm,
	input  wire logic [7:0] status_register,
	output logic      [7:0] res,
	output logic            res_we,
	output logic      [7:0] status_register_out
);
	// common flag update of both right shifts
	function automatic logic [7:0] shift_flags(input logic [7:0] s,
		input logic [7:0] r, input logic c);
		logic [7:0] f;
		f = s;
		f[cpu_exec_pkg::FLAG_C] = c;
		f[cpu_exec_pkg::FLAG_Z] = (r == 8'h00);
		f[cpu_exec_pkg::FLAG_N] = r[7];
		f[cpu_exec_pkg::FLAG_V] = r[7] ^ c;
		return f;
	endfunction

	// result and flags per operation
	always_comb
	begin
		res = rd_val;
		res_we = 1'b0;
		status_register_out = status_register;
		case (op)
		cpu_exec_pkg::OP_ROTATE_RIGHT_CARRY:
		begin
			res = {status_register[cpu_exec_pkg::FLAG_C], rd_val[7:1]};
			res_we = 1'b1;
			status_register_out = shift_flags(status_register, res, rd_val[0]);
		end
		cpu_exec_pkg::OP_ARITH_SHIFT_RIGHT:
		begin
			res = {rd_val[7], rd_val[7:1]};
			res_we = 1'b1;
			status_register_out = shift_flags(status_register, res, rd_val[0]);
		end
		cpu_exec_pkg::OP_NIBBLE_SWAP:
		begin
			res = {rd_val[3:0], rd_val[7:4]};
			res_we = 1'b1;
		end
		cpu_exec_pkg::OP_FLAG_SET_GENERIC:
			status_register_out[bit_sel] = 1'b1;
		cpu_exec_pkg::OP_FLAG_CLEAR_GENERIC:
			status_register_out[bit_sel] = 1'b0;
		cpu_exec_pkg::OP_BIT_TO_TRANSFER_FLAG:
			status_register_out[cpu_exec_pkg::FLAG_T] = rr_val[bit_sel];
		cpu_exec_pkg::OP_TRANSFER_FLAG_TO_BIT:
		begin
			res[bit_sel] = status_register[cpu_exec_pkg::FLAG_T];
			res_we = 1'b1;
		end
		cpu_exec_pkg::OP_REGISTER_MOVE:
		begin
			res = rr_val;
			res_we = 1'b1;
		end
		cpu_exec_pkg::OP_IMMEDIATE_LOAD:
		begin
			res = imm;
			res_we = 1'b1;
		end
		default:
			res_we = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ==== design/cpu_bitops_load_store_exec.sv ====
// Purpose: executes bit, move and load/store commands issued over APB
// Assumes: data memory answers a read within the cycle dmem_re is high
// Notes:   one APB wait state; writes refused with pslverr while busy
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cpu_bitops_load_store_exec (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	output wire logic [15:0] dmem_addr,
	output wire logic [7:0]  dmem_wdata,
	output wire logic        dmem_we,
	output wire logic        dmem_re,
	input  wire logic [7:0]  dmem_rdata
);
	cpu_exec_pkg::exec_state_t state_reg;
	cpu_exec_pkg::exec_state_t state_next;
	logic [31:0] cmd_reg;
	logic [15:0] operand_reg;
	logic [7:0]  status_register_reg;
	logic        err_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [15:0] dmem_addr_reg;
	logic [7:0]  dmem_wdata_reg;
	logic        dmem_we_reg;
	logic        dmem_re_reg;
	logic [7:0]  rd_val;
	logic [7:0]  rr_val;
	logic [7:0]  win_val;
	logic [15:0] ptr_val;
	logic [15:0] pair_src;
	logic [7:0]  alu_res;
	logic        alu_we;
	logic [7:0]  alu_status_register;

	// pointer select to register pair index
	function automatic logic [3:0] ptr_pair(input logic [1:0] sel);
		return cpu_exec_pkg::PTR_PAIR_BASE + {2'b00, sel};
	endfunction

	// command fields
	wire [4:0] cmd_op  = cmd_reg[cpu_exec_pkg::CMD_OP_LSB +: 5];
	wire [4:0] cmd_rd  = cmd_reg[cpu_exec_pkg::CMD_RD_LSB +: 5];
	wire [4:0] cmd_rr  = cmd_reg[cpu_exec_pkg::CMD_RR_LSB +: 5];
	wire [2:0] bit_sel = cmd_reg[cpu_exec_pkg::CMD_BIT_LSB +: 3];
	wire [1:0] ptr_sel = cmd_reg[cpu_exec_pkg::CMD_PTR_LSB +: 2];

	// operation classes
	wire is_pre_dec  = cmd_op == cpu_exec_pkg::OP_LOAD_PRE_DEC
		|| cmd_op == cpu_exec_pkg::OP_STORE_PRE_DEC;
	wire is_post_inc = cmd_op == cpu_exec_pkg::OP_LOAD_POST_INC
		|| cmd_op == cpu_exec_pkg::OP_STORE_POST_INC;
	wire is_disp     = cmd_op == cpu_exec_pkg::OP_DISPLACEMENT_LOAD;
	wire is_direct   = cmd_op == cpu_exec_pkg::OP_DIRECT_LOAD;
	wire is_load     = cmd_op >= cpu_exec_pkg::OP_INDIRECT_LOAD
		&& cmd_op <= cpu_exec_pkg::OP_DIRECT_LOAD;
	wire is_store    = cmd_op >= cpu_exec_pkg::OP_INDIRECT_STORE
		&& cmd_op <= cpu_exec_pkg::OP_STORE_PRE_DEC;
	wire is_mem      = is_load || is_store;
	wire is_pair     = cmd_op == cpu_exec_pkg::OP_REGISTER_PAIR_COPY;

	// bad commands are dropped; displacement only through upper pointers
	wire cmd_bad = cmd_op > cpu_exec_pkg::OP_STORE_PRE_DEC
		|| (is_mem && !is_direct && ptr_sel == cpu_exec_pkg::PTR_NONE)
		|| (is_disp && ptr_sel == cpu_exec_pkg::PTR_X);
	wire busy    = state_reg != cpu_exec_pkg::S_IDLE;
	wire in_exec = state_reg == cpu_exec_pkg::S_EXEC;
	wire in_mem  = state_reg == cpu_exec_pkg::S_MEM;
	wire exec_ok = in_exec && !cmd_bad;

	// effective address and pointer step
	wire [15:0] ptr_dec  = ptr_val - 16'h0001;
	wire [15:0] ptr_inc  = ptr_val + 16'h0001;
	wire [15:0] ptr_disp = ptr_val + {10'h000, operand_reg[5:0]};
	wire [15:0] mem_addr = is_pre_dec ? ptr_dec
		: is_disp ? ptr_disp
		: is_direct ? operand_reg
		: ptr_val;
	wire [15:0] ptr_new  = is_pre_dec ? ptr_dec : ptr_inc;
	wire        ptr_step = is_pre_dec || is_post_inc;

	// apb decode; the answer is prepared in the first access cycle
	wire hit_cmd  = paddr == cpu_exec_pkg::ADDR_CMD;
	wire hit_op   = paddr == cpu_exec_pkg::ADDR_OPERAND;
	wire hit_stat = paddr == cpu_exec_pkg::ADDR_STATUS;
	wire hit_win  = paddr[cpu_exec_pkg::REGWIN_BIT] && paddr[1:0] == 2'b00;
	wire mapped   = hit_cmd || hit_op || hit_stat || hit_win;
	wire refuse   = !mapped || (pwrite && busy);
	wire acc_wait = psel && penable && !pready_reg;
	wire acc_done = psel && penable && pready_reg;
	wire wr_ok    = acc_done && pwrite && !refuse;
	wire start    = wr_ok && hit_cmd;
	wire err_clr  = wr_ok && hit_stat
		&& pwdata[cpu_exec_pkg::STATUS_ERR_BIT];
	wire [31:0] rd_word = hit_cmd ? cmd_reg
		: hit_op ? {16'h0000, operand_reg}
		: hit_stat ? {22'h000000, err_reg, busy, status_register_reg}
		: hit_win ? {24'h000000, win_val}
		: 32'h0000_0000;

	// register file write sources
	wire        byte_we   = (exec_ok && alu_we) || (in_mem && is_load)
		|| (wr_ok && hit_win);
	wire [4:0]  byte_addr = busy ? cmd_rd : paddr[6:2];
	wire [7:0]  byte_data = in_mem ? dmem_rdata
		: busy ? alu_res : pwdata[7:0];
	wire        word_we   = exec_ok && (is_pair || ptr_step);
	wire [3:0]  word_pair = is_pair ? cmd_rd[4:1] : ptr_pair(ptr_sel);
	wire [15:0] word_data = is_pair ? pair_src : ptr_new;

	// sticky error: a new bad command beats a clear in the same cycle
	wire        err_next  = (in_exec && cmd_bad) || (err_reg && !err_clr);
	wire [7:0]  status_register_next = exec_ok ? alu_status_register
		: (wr_ok && hit_stat) ? pwdata[7:0] : status_register_reg;

	work_regs u_regs (
		.mclk      (mclk),
		.reset     (reset),
		.a_addr    (cmd_rd),
		.b_addr    (cmd_rr),
		.c_addr    (paddr[6:2]),
		.p_pair    (ptr_pair(ptr_sel)),
		.q_pair    (cmd_rr[4:1]),
		.byte_we   (byte_we),
		.byte_addr (byte_addr),
		.byte_data (byte_data),
		.word_we   (word_we),
		.word_pair (word_pair),
		.word_data (word_data),
		.a_data    (rd_val),
		.b_data    (rr_val),
		.c_data    (win_val),
		.p_data    (ptr_val),
		.q_data    (pair_src)
	);

	exec_alu u_alu (
		.op       (cmd_op),
		.rd_val   (rd_val),
		.rr_val   (rr_val),
		.bit_sel  (bit_sel),
		.imm      (operand_reg[7:0]),
		.status_register     (status_register_reg),
		.res      (alu_res),
		.res_we   (alu_we),
		.status_register_out (alu_status_register)
	);

	// sequencer: one exec cycle, plus one memory cycle for loads/stores
	always_comb
	begin
		state_next = cpu_exec_pkg::S_IDLE;
		case (state_reg)
		cpu_exec_pkg::S_IDLE:
			state_next = start ? cpu_exec_pkg::S_EXEC : cpu_exec_pkg::S_IDLE;
		cpu_exec_pkg::S_EXEC:
			state_next = (exec_ok && is_mem) ? cpu_exec_pkg::S_MEM
				: cpu_exec_pkg::S_IDLE;
		cpu_exec_pkg::S_MEM:
			state_next = cpu_exec_pkg::S_IDLE;
		default:
			state_next = cpu_exec_pkg::S_IDLE;
		endcase
	end

	// control and software-visible state
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_reg   <= cpu_exec_pkg::S_IDLE;
			cmd_reg     <= cpu_exec_pkg::CMD_RESET;
			operand_reg <= cpu_exec_pkg::OPERAND_RESET;
			status_register_reg    <= cpu_exec_pkg::STATUS_REGISTER_RESET;
			err_reg     <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			status_register_reg  <= status_register_next;
			err_reg   <= err_next;
			if (start)
				cmd_reg <= pwdata;
			if (wr_ok && hit_op)
				operand_reg <= pwdata[15:0];
		end
	end

	// apb answer registers; pready pulses for one cycle
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end
		else
		begin
			pready_reg  <= acc_wait;
			pslverr_reg <= acc_wait && refuse;
			prdata_reg  <= (acc_wait && !pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// data memory request; address held between accesses
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			dmem_addr_reg  <= 16'h0000;
			dmem_wdata_reg <= 8'h00;
			dmem_we_reg    <= 1'b0;
			dmem_re_reg    <= 1'b0;
		end
		else
		begin
			dmem_we_reg <= exec_ok && is_store;
			dmem_re_reg <= exec_ok && is_load;
			if (exec_ok && is_mem)
			begin
				dmem_addr_reg  <= mem_addr;
				dmem_wdata_reg <= rr_val;
			end
		end
	end

	assign prdata     = prdata_reg;
	assign pready     = pready_reg;
	assign pslverr    = pslverr_reg;
	assign dmem_addr  = dmem_addr_reg;
	assign dmem_wdata = dmem_wdata_reg;
	assign dmem_we    = dmem_we_reg;
	assign dmem_re    = dmem_re_reg;

	// checks on the executed commands
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property p_rotate;
		exec_ok && cmd_op == cpu_exec_pkg::OP_ROTATE_RIGHT_CARRY |=>
			rd_val == {$past(status_register_reg[0]), $past(rd_val[7:1])}
			&& status_register_reg[0] == $past(rd_val[0]) && !busy;
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate wrong");

	property p_shift;
		exec_ok && cmd_op == cpu_exec_pkg::OP_ARITH_SHIFT_RIGHT |=>
			rd_val == {$past(rd_val[7]), $past(rd_val[7:1])}
			&& status_register_reg[1] == (rd_val == 8'h00);
	endproperty
	a_shift: assert property (p_shift) else $error("shift wrong");

	property p_swap;
		exec_ok && cmd_op == cpu_exec_pkg::OP_NIBBLE_SWAP |=>
			rd_val == {$past(rd_val[3:0]), $past(rd_val[7:4])}
			&& $stable(status_register_reg);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_to_t;
		exec_ok && cmd_op == cpu_exec_pkg::OP_BIT_TO_TRANSFER_FLAG |=>
			status_register_reg[6] == $past(rr_val[bit_sel])
			&& {status_register_reg[7], status_register_reg[5:0]}
			== $past({status_register_reg[7], status_register_reg[5:0]});
	endproperty
	a_to_t: assert property (p_to_t) else $error("bit store wrong");

	property p_from_t;
		exec_ok && cmd_op == cpu_exec_pkg::OP_TRANSFER_FLAG_TO_BIT |=>
			rd_val[bit_sel] == status_register_reg[6] && $stable(status_register_reg);
	endproperty
	a_from_t: assert property (p_from_t) else $error("bit load wrong");

	property p_fset;
		exec_ok && cmd_op == cpu_exec_pkg::OP_FLAG_SET_GENERIC |=>
			status_register_reg == ($past(status_register_reg) | (8'h01 << bit_sel)) && !busy;
	endproperty
	a_fset: assert property (p_fset) else $error("flag set wrong");

	property p_fclr;
		exec_ok && cmd_op == cpu_exec_pkg::OP_FLAG_CLEAR_GENERIC |=>
			status_register_reg == ($past(status_register_reg) & ~(8'h01 << bit_sel));
	endproperty
	a_fclr: assert property (p_fclr) else $error("flag clear wrong");

	property p_ovf;
		exec_ok && bit_sel == cpu_exec_pkg::FLAG_V
			&& (cmd_op == cpu_exec_pkg::OP_FLAG_SET_GENERIC
			|| cmd_op == cpu_exec_pkg::OP_FLAG_CLEAR_GENERIC) |=>
			status_register_reg[3] == (cmd_op == cpu_exec_pkg::OP_FLAG_SET_GENERIC)
			&& {status_register_reg[7:4], status_register_reg[2:0]}
			== $past({status_register_reg[7:4], status_register_reg[2:0]});
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

	property p_load_inc;
		exec_ok && cmd_op == cpu_exec_pkg::OP_LOAD_POST_INC |=>
			dmem_re && dmem_addr == $past(ptr_val)
			&& ptr_val == dmem_addr + 16'h0001 ##1 !busy;
	endproperty
	a_load_inc: assert property (p_load_inc) else $error("ld inc");

	property p_load_dec;
		exec_ok && cmd_op == cpu_exec_pkg::OP_LOAD_PRE_DEC |=>
			dmem_re && dmem_addr == $past(ptr_val) - 16'h0001
			&& ptr_val == dmem_addr;
	endproperty
	a_load_dec: assert property (p_load_dec) else $error("ld dec");

	property p_load_disp;
		exec_ok && is_disp |=> dmem_re && $stable(ptr_val)
			&& dmem_addr == $past(ptr_val) + {10'h000, operand_reg[5:0]}
			##1 !busy && !dmem_re;
	endproperty
	a_load_disp: assert property (p_load_disp) else $error("ld disp");

	property p_load_direct;
		exec_ok && is_direct |=> dmem_re && dmem_addr == operand_reg
			##1 !busy && rd_val == $past(dmem_rdata) && $stable(status_register_reg);
	endproperty
	a_load_direct: assert property (p_load_direct) else $error("ld dir");

	property p_store_inc;
		exec_ok && cmd_op == cpu_exec_pkg::OP_STORE_POST_INC |=>
			dmem_we && dmem_wdata == $past(rr_val)
			&& dmem_addr == $past(ptr_val)
			&& ptr_val == $past(ptr_val) + 16'h0001 ##1 !dmem_we && !busy;
	endproperty
	a_store_inc: assert property (p_store_inc) else $error("st inc");

	property p_store_dec;
		exec_ok && cmd_op == cpu_exec_pkg::OP_STORE_PRE_DEC |=>
			dmem_we && ptr_val == $past(ptr_val) - 16'h0001
			&& dmem_addr == ptr_val;
	endproperty
	a_store_dec: assert property (p_store_dec) else $error("st dec");

	property p_move;
		exec_ok && cmd_op == cpu_exec_pkg::OP_REGISTER_MOVE |=>
			rd_val == $past(rr_val) && $stable(status_register_reg) && !busy;
	endproperty
	a_move: assert property (p_move) else $error("move wrong");
endmodule
`default_nettype wire

// ==== dv/dmem_model.sv ====
// Purpose: data memory model beside the executor
// Assumes: read data due within the cycle in which dmem_re is high
// Notes:   a released data bus shows the inverse of the last word read
`timescale 1ns/10ps
`default_nettype none
module dmem_model (
	input  wire logic        mclk,
	input  wire logic [15:0] dmem_addr,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we,
	input  wire logic        dmem_re,
	output wire logic [7:0]  dmem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_rd;

	initial last_rd = 8'h00;

	// writes land at the edge that ends the strobe cycle
	always @(posedge mclk)
	begin
		if (dmem_we)
			mem[dmem_addr] <= dmem_wdata;
		if (dmem_re)
			last_rd <= mem[dmem_addr];
	end

	// answer inside the strobe cycle; inverse otherwise so a late
	// sample shows up as wrong data
	assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~last_rd;
endmodule
`default_nettype wire

// ==== dv/cpu_bitops_load_store_exec_tb.sv ====
// Purpose: self-checking bench of the bit-op and load/store executor
// Assumes: apb slave answers in its own time, bench waits bounded
// Notes:   memory preset by the bench through the model's array
`timescale 1ns/10ps
`default_nettype none
module cpu_bitops_load_store_exec_tb;
	logic        mclk, reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, dmem_wdata, dmem_rdata;
	logic [31:0] pwdata, prdata, rd_v;
	logic [15:0] dmem_addr;
	logic        dmem_we, dmem_re, er;
	int          miscompares, checks_done;

	cpu_bitops_load_store_exec dut (.mclk(mclk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
		.dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata));
	dmem_model mdl (.mclk(mclk), .dmem_addr(dmem_addr),
		.dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
		.dmem_rdata(dmem_rdata));

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; request held until pready seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			chk("pready", 32'h0, 32'h1);
		rd_v = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wreg(input int n, input logic [7:0] v);
		apb(1'b1, 8'h80 + {1'b0, n[4:0], 2'b00}, {24'h0, v});
	endtask

	task automatic creg(input int n, input logic [7:0] v);
		apb(1'b0, 8'h80 + {1'b0, n[4:0], 2'b00}, 32'h0);
		chk("work reg", rd_v, {24'h0, v});
	endtask

	task automatic wsr(input logic [7:0] v);
		apb(1'b1, cpu_exec_pkg::ADDR_STATUS, {24'h0, v});
	endtask

	// status word: idle, no error, given flags
	task automatic csr(input logic [7:0] v);
		apb(1'b0, cpu_exec_pkg::ADDR_STATUS, 32'h0);
		chk("status", rd_v, {24'h0, v});
	endtask

	// issue one command and poll busy, bounded
	task automatic run(input logic [4:0] op, input int d, s, b, p, k);
		int n;
		n = 0;
		apb(1'b1, cpu_exec_pkg::ADDR_OPERAND, {16'h0, k[15:0]});
		apb(1'b1, cpu_exec_pkg::ADDR_CMD, {2'b00, p[1:0], 1'b0, b[2:0],
			3'b0, s[4:0], 3'b0, d[4:0], 3'b0, op});
		do
		begin
			apb(1'b0, cpu_exec_pkg::ADDR_STATUS, 32'h0);
			n++;
		end
		while (rd_v[cpu_exec_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 8);
		// a command that never finishes counts as a mismatch
		chk("busy", {31'h0, rd_v[cpu_exec_pkg::STATUS_BUSY_BIT]},
			32'h0);
	endtask

	task automatic t_shift();
		wreg(1, 8'h81);
		wsr(8'h31);
		run(cpu_exec_pkg::OP_ROTATE_RIGHT_CARRY, 1, 0, 0, 0, 0);
		creg(1, 8'hc0);
		csr(8'h35);
		wreg(2, 8'h80);
		wsr(8'h20);
		run(cpu_exec_pkg::OP_ARITH_SHIFT_RIGHT, 2, 0, 0, 0, 0);
		creg(2, 8'hc0);
		csr(8'h2c);
		wreg(2, 8'h01);
		run(cpu_exec_pkg::OP_ARITH_SHIFT_RIGHT, 2, 0, 0, 0, 0);
		creg(2, 8'h00);
		csr(8'h2b);
		wreg(3, 8'h5a);
		wsr(8'ha5);
		run(cpu_exec_pkg::OP_NIBBLE_SWAP, 3, 0, 0, 0, 0);
		creg(3, 8'ha5);
		csr(8'ha5);
	endtask

	// every flag set from all-clear, cleared from all-set
	task automatic t_flags();
		for (int b = 0; b < 8; b++)
		begin
			wsr(8'h00);
			run(cpu_exec_pkg::OP_FLAG_SET_GENERIC, 0, 0, b, 0, 0);
			csr(8'h01 << b);
			wsr(8'hff);
			run(cpu_exec_pkg::OP_FLAG_CLEAR_GENERIC, 0, 0, b, 0, 0);
			csr(~(8'h01 << b));
		end
	endtask

	task automatic t_bits();
		wreg(4, 8'h10);
		wsr(8'hbf);
		run(cpu_exec_pkg::OP_BIT_TO_TRANSFER_FLAG, 0, 4, 4, 0, 0);
		csr(8'hff);
		run(cpu_exec_pkg::OP_BIT_TO_TRANSFER_FLAG, 0, 4, 3, 0, 0);
		csr(8'hbf);
		wreg(5, 8'h00);
		wsr(8'h40);
		run(cpu_exec_pkg::OP_TRANSFER_FLAG_TO_BIT, 5, 0, 7, 0, 0);
		creg(5, 8'h80);
		csr(8'h40);
	endtask

	task automatic t_moves();
		wsr(8'h55);
		wreg(6, 8'h3c);
		wreg(8, 8'h11);
		wreg(9, 8'h22);
		run(cpu_exec_pkg::OP_REGISTER_MOVE, 7, 6, 0, 0, 0);
		creg(7, 8'h3c);
		run(cpu_exec_pkg::OP_REGISTER_PAIR_COPY, 10, 8, 0, 0, 0);
		creg(10, 8'h11);
		creg(11, 8'h22);
		run(cpu_exec_pkg::OP_IMMEDIATE_LOAD, 12, 0, 0, 0, 32'he7);
		creg(12, 8'he7);
		csr(8'h55);
	endtask

	// pointers: x at 0100, y at 0200, z at 0300
	task automatic t_mem();
		wreg(26, 8'h00);
		wreg(27, 8'h01);
		wreg(28, 8'h00);
		wreg(29, 8'h02);
		wreg(30, 8'h00);
		wreg(31, 8'h03);
		run(cpu_exec_pkg::OP_LOAD_POST_INC, 1, 0, 0, 0, 0);
		creg(1, 8'h9a);
		creg(26, 8'h01);
		chk("mem addr", {16'h0, dmem_addr}, 32'h0100);
		run(cpu_exec_pkg::OP_LOAD_PRE_DEC, 2, 0, 0, 1, 0);
		creg(2, 8'h5b);
		creg(28, 8'hff);
		creg(29, 8'h01);
		run(cpu_exec_pkg::OP_DISPLACEMENT_LOAD, 3, 0, 0, 2, 32'h5);
		creg(3, 8'hc4);
		creg(30, 8'h00);
		chk("mem addr", {16'h0, dmem_addr}, 32'h0305);
		run(cpu_exec_pkg::OP_DIRECT_LOAD, 4, 0, 0, 0, 32'habc);
		creg(4, 8'h17);
		run(cpu_exec_pkg::OP_STORE_POST_INC, 0, 6, 0, 0, 0);
		chk("mem", {24'h0, mdl.mem[16'h0101]}, 32'h3c);
		creg(26, 8'h02);
		run(cpu_exec_pkg::OP_STORE_PRE_DEC, 0, 12, 0, 2, 0);
		chk("mem", {24'h0, mdl.mem[16'h02ff]}, 32'he7);
		creg(30, 8'hff);
		creg(31, 8'h02);
		// plain indirect forms: pointer left as it was
		run(cpu_exec_pkg::OP_INDIRECT_LOAD, 5, 0, 0, 1, 0);
		creg(5, 8'h5b);
		creg(28, 8'hff);
		run(cpu_exec_pkg::OP_INDIRECT_STORE, 0, 7, 0, 2, 0);
		chk("mem", {24'h0, mdl.mem[16'h02ff]}, 32'h3c);
		csr(8'h55);
	endtask

	// bad commands raise only the sticky error; writing one clears it
	task automatic t_err();
		wsr(8'h5a);
		run(5'h13, 1, 0, 0, 0, 0);
		chk("bad op", rd_v, 32'h0000_025a);
		apb(1'b1, cpu_exec_pkg::ADDR_STATUS, 32'h0000_025a);
		csr(8'h5a);
		run(cpu_exec_pkg::OP_DISPLACEMENT_LOAD, 1, 0, 0, 0, 0);
		chk("disp via x", rd_v, 32'h0000_025a);
		creg(1, 8'h9a);
		creg(26, 8'h02);
	endtask

	// free-running bench clock
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// hang guard, well beyond the full sequence
	initial
	begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		test_done();
	end

	initial
	begin
		miscompares = 0;
		checks_done = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mdl.mem[16'h0100] = 8'h9a;
		mdl.mem[16'h01ff] = 8'h5b;
		mdl.mem[16'h0305] = 8'hc4;
		mdl.mem[16'h0abc] = 8'h17;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		csr(8'h00);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		chk("unmapped data", rd_v, 32'h0);
		t_shift();
		t_flags();
		t_bits();
		t_moves();
		t_mem();
		t_err();
		test_done();
	end
endmodule
`default_nettype wire
